// File: pkg/dldma_pkg.sv
package dldma_pkg;
   // descriptor word offsets, bytes from the descriptor base
   localparam logic [31:0] DLDMA_OFS_LINK = 32'h0000_0000;
   localparam logic [31:0] DLDMA_OFS_CMD = 32'h0000_0004;
   localparam logic [31:0] DLDMA_OFS_BUF = 32'h0000_0008;
   localparam logic [31:0] DLDMA_OFS_BUF_LEGACY = 32'h0000_000C;
   localparam logic [31:0] DLDMA_WORD_STEP = 32'h0000_0004;
   // command/status field positions
   localparam int DLDMA_BIT_OWN = 31;
   localparam int DLDMA_BIT_MORE = 30;
   localparam int DLDMA_BIT_IRQ = 29;
   localparam int DLDMA_BIT_FCS = 28;
   localparam int DLDMA_BIT_OK = 27;
   localparam int DLDMA_DIR_LO = 16;
   localparam int DLDMA_DIR_W = 11;
   localparam int DLDMA_RSV_LO = 12;
   localparam int DLDMA_RSV_W = 4;
   localparam int DLDMA_SIZE_W = 12;
   // values after reset, plus the count step and the last byte lane
   localparam logic [31:0] DLDMA_RST_WORD = 32'h0000_0000;
   localparam logic [11:0] DLDMA_RST_CNT = 12'h000;
   localparam logic [11:0] DLDMA_ONE_CNT = 12'h001;
   localparam logic [10:0] DLDMA_RST_DIR = 11'h000;
   localparam logic [1:0] DLDMA_LAST_LANE = 2'h3;

   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } dldma_mem_t;

   typedef struct packed {
      logic valid;
      logic ok;
      logic [10:0] status;
   } dldma_done_t;

   typedef enum {
      DLDMA_IDLE, DLDMA_LINK, DLDMA_CMD, DLDMA_BUF, DLDMA_WAIT, DLDMA_FETCH,
      DLDMA_TXB, DLDMA_TXDONE, DLDMA_RXB, DLDMA_WRD, DLDMA_WB
   } dldma_state_t;
endpackage

// File: verilog/dldma_cmdsts.sv
`timescale 1ns/10ps
module dldma_cmdsts import dldma_pkg::*; (
   input wire logic [31:0] orig,
   input wire logic isRx,
   input wire logic isFinal,
   input wire logic pktOk,
   input wire logic [10:0] dirStatus,
   input wire logic [11:0] byteCount,
   output logic [31:0] word
);
   always_comb begin
      word = DLDMA_RST_WORD;
      word[DLDMA_BIT_OWN] = isRx;
      word[DLDMA_BIT_MORE] = ~isFinal;
      word[DLDMA_BIT_IRQ] = orig[DLDMA_BIT_IRQ];
      word[DLDMA_BIT_FCS] = isRx | orig[DLDMA_BIT_FCS];
      word[DLDMA_BIT_OK] = isFinal & pktOk;
      // direction bits carry whichever side's status, final descriptor only
      if (isFinal) begin
         word[DLDMA_DIR_LO +: DLDMA_DIR_W] = dirStatus;
      end
      word[DLDMA_RSV_LO +: DLDMA_RSV_W] = '0;
      word[DLDMA_SIZE_W-1:0] = byteCount;
   end
endmodule

// File: verilog/dldma_engine.sv
`timescale 1ns/10ps
module dldma_engine import dldma_pkg::*; (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic startPulse,
   input wire logic resumePoll,
   input wire logic rxMode,
   input wire logic legacyLayoutSelect,
   input wire logic [31:0] listHead,
   output logic engineIdle,
   output logic waitOwn,
   output dldma_mem_t memOut,
   input wire logic memAck,
   input wire logic [31:0] memRdata,
   output logic [7:0] txData,
   output logic txValid,
   output logic txLast,
   output logic suppressFcsFlag,
   input wire logic txReady,
   input wire dldma_done_t txDone,
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   input wire dldma_done_t rxEnd,
   output logic rxReady,
   output logic descriptorIrqRequest
);
   dldma_state_t state_r;
   logic [31:0] descAddr_r;
   logic [31:0] link_r;
   logic [31:0] cmd_r;
   logic [31:0] curAddr_r;
   logic [31:0] word_r;
   logic [11:0] cnt_r;
   logic [7:0] txData_r;
   logic pktFirst_r;
   logic ended_r;
   logic suppress_r;
   logic irq_r;
   dldma_done_t done_r;
   logic [31:0] wbWord;
   logic owned;
   logic isFinal;
   logic [11:0] size;
   logic [11:0] cntInc;
   logic [11:0] wbCount;

   assign size = cmd_r[DLDMA_SIZE_W-1:0];
   assign cntInc = cnt_r + DLDMA_ONE_CNT;
   // receive owns an empty descriptor while bit 31 is clear
   assign owned = rxMode ? ~memRdata[DLDMA_BIT_OWN] : memRdata[DLDMA_BIT_OWN];
   assign isFinal = rxMode ? ended_r : ~cmd_r[DLDMA_BIT_MORE];
   assign wbCount = rxMode ? cnt_r : size;

   dldma_cmdsts u_cmdsts (
      .orig(cmd_r),
      .isRx(rxMode),
      .isFinal(isFinal),
      .pktOk(done_r.ok),
      .dirStatus(done_r.status),
      .byteCount(wbCount),
      .word(wbWord)
   );
   always_comb begin
      memOut = '0;
      case (state_r)
         DLDMA_LINK: begin
            memOut.req = 1'b1;
            memOut.addr = descAddr_r + DLDMA_OFS_LINK;
         end
         DLDMA_CMD: begin
            memOut.req = 1'b1;
            memOut.addr = descAddr_r + DLDMA_OFS_CMD;
         end
         DLDMA_BUF: begin
            memOut.req = 1'b1;
            // legacy layout fetches the buffer pointer from the word at offset 0xC
            memOut.addr = descAddr_r + (legacyLayoutSelect ?
               DLDMA_OFS_BUF_LEGACY : DLDMA_OFS_BUF);
         end
         DLDMA_FETCH: begin
            memOut.req = 1'b1;
            memOut.addr = {curAddr_r[31:2], 2'b00};
         end
         DLDMA_WRD: begin
            memOut.req = 1'b1;
            memOut.we = 1'b1;
            memOut.addr = {curAddr_r[31:2], 2'b00};
            memOut.wdata = word_r;
         end
         DLDMA_WB: begin
            memOut.req = 1'b1;
            memOut.we = 1'b1;
            memOut.addr = descAddr_r + DLDMA_OFS_CMD;
            memOut.wdata = wbWord;
         end
         default: memOut = '0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= DLDMA_IDLE;
         descAddr_r <= DLDMA_RST_WORD;
         link_r <= DLDMA_RST_WORD;
         cmd_r <= DLDMA_RST_WORD;
         curAddr_r <= DLDMA_RST_WORD;
         cnt_r <= DLDMA_RST_CNT;
         pktFirst_r <= 1'b1;
         ended_r <= 1'b0;
      end else begin
         case (state_r)
            DLDMA_IDLE: begin
               if (startPulse) begin
                  descAddr_r <= {listHead[31:2], 2'b00};
                  pktFirst_r <= 1'b1;
                  ended_r <= 1'b0;
                  state_r <= DLDMA_LINK;
               end
            end
            DLDMA_LINK: begin
               if (memAck) begin
                  link_r <= {memRdata[31:2], 2'b00};
                  state_r <= DLDMA_CMD;
               end
            end
            DLDMA_CMD: begin
               if (memAck) begin
                  cmd_r <= memRdata;
                  state_r <= owned ? DLDMA_BUF : DLDMA_WAIT;
               end
            end
            DLDMA_WAIT: begin
               if (resumePoll) begin
                  state_r <= DLDMA_CMD;
               end
            end
            DLDMA_BUF: begin
               if (memAck) begin
                  curAddr_r <= memRdata;
                  cnt_r <= DLDMA_RST_CNT;
                  if (size == DLDMA_RST_CNT) begin
                     state_r <= (!rxMode && isFinal) ? DLDMA_TXDONE : DLDMA_WB;
                  end else begin
                     state_r <= rxMode ? DLDMA_RXB : DLDMA_FETCH;
                  end
               end
            end
            DLDMA_FETCH: begin
               if (memAck) begin
                  state_r <= DLDMA_TXB;
               end
            end
            DLDMA_TXB: begin
               if (txReady) begin
                  cnt_r <= cntInc;
                  curAddr_r <= curAddr_r + 32'h0000_0001;
                  if (cntInc == size) begin
                     state_r <= isFinal ? DLDMA_TXDONE : DLDMA_WB;
                  end else if (curAddr_r[1:0] == DLDMA_LAST_LANE) begin
                     state_r <= DLDMA_FETCH;
                  end
               end
            end
            DLDMA_TXDONE: begin
               if (txDone.valid) begin
                  state_r <= DLDMA_WB;
               end
            end
            DLDMA_RXB: begin
               if (rxValid) begin
                  cnt_r <= cntInc;
                  ended_r <= rxEnd.valid;
                  if (rxEnd.valid || cnt_r[1:0] == DLDMA_LAST_LANE || cntInc == size) begin
                     state_r <= DLDMA_WRD;
                  end
               end
            end
            DLDMA_WRD: begin
               if (memAck) begin
                  curAddr_r <= {curAddr_r[31:2], 2'b00} + DLDMA_WORD_STEP;
                  // a full buffer mid-packet spills into the next descriptor
                  state_r <= (ended_r || cnt_r == size) ? DLDMA_WB : DLDMA_RXB;
               end
            end
            DLDMA_WB: begin
               if (memAck) begin
                  pktFirst_r <= isFinal;
                  ended_r <= 1'b0;
                  descAddr_r <= link_r;
                  // a null link ends the walk rather than reading address zero
                  state_r <= (link_r == DLDMA_RST_WORD) ? DLDMA_IDLE : DLDMA_LINK;
               end
            end
            default: state_r <= DLDMA_IDLE;
         endcase
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         word_r <= DLDMA_RST_WORD;
         txData_r <= 8'h00;
      end else if (state_r == DLDMA_FETCH && memAck) begin
         word_r <= memRdata;
         txData_r <= memRdata[{curAddr_r[1:0], 3'b000} +: 8];
      end else if (state_r == DLDMA_TXB && txReady) begin
         txData_r <= word_r[{curAddr_r[1:0] + 2'h1, 3'b000} +: 8];
      end else if (state_r == DLDMA_RXB && rxValid) begin
         // fcs bytes arrive as data and land in the buffer like any other
         word_r[{cnt_r[1:0], 3'b000} +: 8] <= rxData;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         done_r <= '0;
         suppress_r <= 1'b0;
      end else begin
         if (state_r == DLDMA_BUF && memAck && pktFirst_r) begin
            suppress_r <= ~rxMode & cmd_r[DLDMA_BIT_FCS];
         end
         if (state_r == DLDMA_TXDONE && txDone.valid) begin
            done_r <= txDone;
         end else if (state_r == DLDMA_RXB && rxValid && rxEnd.valid) begin
            done_r <= rxEnd;
         end else if (state_r == DLDMA_WB && memAck) begin
            done_r <= '0;
         end
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= state_r == DLDMA_WB && memAck && cmd_r[DLDMA_BIT_IRQ];
      end
   end
   assign engineIdle = state_r == DLDMA_IDLE;
   assign waitOwn = state_r == DLDMA_WAIT;
   assign txValid = state_r == DLDMA_TXB;
   assign txData = txData_r;
   assign txLast = txValid && isFinal && cntInc == size;
   assign suppressFcsFlag = suppress_r;
   assign rxReady = state_r == DLDMA_RXB;
   assign descriptorIrqRequest = irq_r;
   sequence wbAccepted;
      state_r == DLDMA_WB && memAck;
   endsequence
   sequence cmdRefused;
      state_r == DLDMA_CMD && memAck && !owned;
   endsequence

   memAlign_a: assert property (@(posedge mclk) disable iff (!rst_n)
      memOut.req |-> memOut.addr[1:0] == 2'b00)
      else $error("descriptor access not word aligned");
   bufOffset_a: assert property (@(posedge mclk) disable iff (!rst_n)
      state_r == DLDMA_BUF |-> memOut.addr - descAddr_r ==
         (legacyLayoutSelect ? DLDMA_OFS_BUF_LEGACY : DLDMA_OFS_BUF))
      else $error("buffer pointer read at wrong offset");
   ownStall_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cmdRefused |=> waitOwn throughout (!memOut.req [*2]))
      else $error("advanced past unowned descriptor");
   wbOwnership_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wbAccepted |-> memOut.wdata[DLDMA_BIT_OWN] == rxMode)
      else $error("ownership written wrong way");
   statusFinal_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wbAccepted and memOut.wdata[DLDMA_BIT_MORE] |->
         memOut.wdata[DLDMA_BIT_OK:DLDMA_DIR_LO] == 12'h000)
      else $error("status in non-final descriptor");
   rxFcsBit_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wbAccepted and rxMode |-> memOut.wdata[DLDMA_BIT_FCS])
      else $error("receive fcs bit not set");
   irqPulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
      descriptorIrqRequest == $past(memAck && memOut.we && memOut.wdata[DLDMA_BIT_IRQ] &&
         memOut.addr == descAddr_r + DLDMA_OFS_CMD))
      else $error("descriptor interrupt mismatch");
   txCount_a: assert property (@(posedge mclk) disable iff (!rst_n)
      txValid && txReady && txLast |=> cnt_r == size ##1 !txValid)
      else $error("transmit byte count mismatch");
   fcsStable_a: assert property (@(posedge mclk) disable iff (!rst_n)
      txValid && !pktFirst_r |-> $stable(suppressFcsFlag))
      else $error("fcs suppression changed inside packet");
endmodule

// File: verif/dldma_mem_model.sv
`timescale 1ns/10ps
module dldma_mem_model import dldma_pkg::*; (
   input wire logic mclk,
   input wire logic rst_n,
   input wire dldma_mem_t memOut,
   input wire logic [1:0] lat,
   output logic memAck,
   output logic [31:0] memRdata
);
   logic [31:0] mem [0:1023];
   logic [1:0] waitCnt_r;
   logic [31:0] last_r;
   // slow or prompt answer, lat cycles after the request shows
   assign memAck = memOut.req && (waitCnt_r >= lat);
   // no data outside the ack: a toggling pattern so a stale read fails
   assign memRdata = memAck ? mem[memOut.addr[11:2]] : ~last_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         waitCnt_r <= 2'h0;
         last_r <= 32'h0000_0000;
      end else begin
         waitCnt_r <= (memAck || !memOut.req) ? 2'h0 : waitCnt_r + 2'h1;
         last_r <= memRdata;
      end
   end
   // host side: aligned links layout owner bits
   always @(posedge mclk) begin
      if (memAck && memOut.we) begin
         mem[memOut.addr[11:2]] <= memOut.wdata;
      end
   end
endmodule

// File: verif/testbench.sv
`timescale 1ns/10ps
`define M dldma_mem_model_inst.mem
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module testbench import dldma_pkg::*;;
   logic mclk = 0, rst_n = 0, startPulse = 0, resumePoll = 0, rxMode = 0;
   logic legacyLayoutSelect = 0, txReady = 0, rxValid = 0, memAck, engineIdle, waitOwn;
   logic txValid, txLast, suppressFcsFlag, rxReady, descriptorIrqRequest, sfcs, okv;
   logic [31:0] listHead = 0, memRdata;
   logic [7:0] txData, rxData = 0;
   logic [1:0] lat = 0;
   logic [10:0] stat;
   dldma_mem_t memOut;
   dldma_done_t txDone = '0, rxEnd = '0;
   int n_mismatch = 0, check_count = 0, seed = 32'hc4cb, cycles = 0, irqs = 0, doneDue = 0, i;
   logic [7:0] gotQ[$], expQ[$];
   dldma_engine dldma_engine_inst (.mclk(mclk), .rst_n(rst_n), .startPulse(startPulse),
      .resumePoll(resumePoll), .rxMode(rxMode), .legacyLayoutSelect(legacyLayoutSelect),
      .listHead(listHead), .engineIdle(engineIdle), .waitOwn(waitOwn), .memOut(memOut),
      .memAck(memAck), .memRdata(memRdata), .txData(txData), .txValid(txValid),
      .txLast(txLast), .suppressFcsFlag(suppressFcsFlag), .txReady(txReady),
      .txDone(txDone), .rxData(rxData), .rxValid(rxValid), .rxEnd(rxEnd),
      .rxReady(rxReady), .descriptorIrqRequest(descriptorIrqRequest));
   dldma_mem_model dldma_mem_model_inst (.mclk(mclk), .rst_n(rst_n), .memOut(memOut),
      .lat(lat), .memAck(memAck), .memRdata(memRdata));
   initial begin
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (descriptorIrqRequest === 1'b1) irqs++;
      if (txValid === 1'b1 && txReady === 1'b1) begin
         if (gotQ.size() == 0) sfcs = suppressFcsFlag;
         gotQ.push_back(txData);
         if (txLast === 1'b1) begin
            doneDue = 1;
            `CHK(gotQ.size(), expQ.size())
         end
      end
      if (cycles > 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   // sink stalls at random; outcome pulse one cycle after the last byte
   always @(negedge mclk) begin
      txReady <= $random(seed);
      txDone <= doneDue ? dldma_done_t'{1'b1, okv, stat} : dldma_done_t'(0);
      doneDue = 0;
   end
   function automatic logic [7:0] mb(int a);
      return `M[a[11:2]][8*a[1:0] +: 8];
   endfunction
   // decoy word in the unused slot catches a wrong layout
   task automatic put(int a, int l, logic [31:0] c, int b, bit leg);
      `M[a/4] = l;
      `M[a/4+1] = c;
      `M[a/4+2] = leg ? ~b : b;
      `M[a/4+3] = leg ? b : ~b;
   endtask
   task automatic go(logic [31:0] h);
      @(negedge mclk);
      listHead <= h;
      startPulse <= 1;
      @(negedge mclk);
      startPulse <= 0;
   endtask
   task automatic waitIdle();
      int k;
      for (k = 0; k < 3000 && engineIdle !== 1'b1; k++) @(negedge mclk);
      // one more edge so the last interrupt pulse gets counted
      @(negedge mclk);
      `CHK(engineIdle, 1'b1)
   endtask
   task automatic txPkt(int n, bit leg, logic [31:0] fl, bit stall);
      int k, j, ir, sz[4], bp[4];
      logic [31:0] c;
      ir = irqs;
      gotQ.delete();
      expQ.delete();
      @(negedge mclk);
      legacyLayoutSelect <= leg;
      rxMode <= 0;
      lat <= $random(seed);
      okv = $random(seed);
      stat = $random(seed);
      for (k = 0; k < n; k++) begin
         sz[k] = ($random(seed) & 7) + 1;
         bp[k] = 32'h800 + 32'h40 * k + ($random(seed) & 3);
         for (j = 0; j < 12; j++) `M[(32'h800 + 32'h40 * k) / 4 + j] = $random(seed);
         for (j = 0; j < sz[k]; j++) expQ.push_back(mb(bp[k] + j));
         c = {1'b1, k < n - 1, 30'h0} | fl | sz[k];
         c[31] = !(stall && k == n - 1);
         put(32'h100 * (k + 1), (k < n - 1) ? 32'h100 * (k + 2) : 0, c, bp[k], leg);
      end
      go(32'h100);
      if (stall) begin
         for (j = 0; j < 3000 && waitOwn !== 1'b1; j++) @(negedge mclk);
         repeat (20) @(negedge mclk);
         `CHK({waitOwn, engineIdle}, 2'b10)
         `M[32'h100 * n / 4 + 1][31] = 1'b1;
         resumePoll <= 1;
         @(negedge mclk);
         resumePoll <= 0;
      end
      waitIdle();
      `CHK(gotQ.size(), expQ.size())
      foreach (expQ[j]) `CHK(gotQ[j], expQ[j])
      `CHK(sfcs, fl[28])
      `CHK(irqs - ir, fl[29] ? n : 0)
      for (k = 0; k < n; k++) begin
         c = {1'b0, k < n - 1, fl[29:28], k == n - 1 && okv, (k == n - 1) ? stat : 11'h0,
            4'h0, sz[k][11:0]};
         `CHK(`M[32'h100 * (k + 1) / 4 + 1], c)
      end
   endtask
   // two 8-byte buffers, the packet spills into the second
   task automatic rxPkt(int nb, bit leg);
      int k, j, t, ir;
      byte unsigned d[$];
      logic [31:0] c;
      ir = irqs;
      @(negedge mclk);
      rxMode <= 1;
      legacyLayoutSelect <= leg;
      lat <= $random(seed);
      okv = $random(seed);
      stat = $random(seed);
      put(32'h100, 32'h200, 32'h2000_0008, 32'h800, leg);
      put(32'h200, 0, 32'h2000_0008, 32'h840, leg);
      go(32'h100);
      for (j = 0; j < nb; j++) begin
         d.push_back($random(seed));
         rxData <= d[j];
         rxValid <= 1;
         rxEnd <= (j == nb - 1) ? dldma_done_t'{1'b1, okv, stat} : dldma_done_t'(0);
         for (t = 0; t < 3000; t++) begin
            #1;
            if (rxReady === 1'b1) break;
            @(negedge mclk);
         end
         @(negedge mclk);
      end
      rxValid <= 0;
      rxEnd <= '0;
      waitIdle();
      foreach (d[j]) `CHK(mb(32'h800 + 32'h40 * (j / 8) + j % 8), d[j])
      `CHK(irqs - ir, 2)
      `CHK(suppressFcsFlag, 1'b0)
      for (k = 0; k < 2; k++) begin
         c = {3'b1_11 ^ {1'b0, k[0], 1'b0}, 1'b1, k[0] & okv, k ? stat : 11'h0, 4'h0,
            k ? 12'(nb - 8) : 12'h008};
         `CHK(`M[32'h100 * (k + 1) / 4 + 1], c)
      end
   endtask
   task automatic conclude();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge mclk);
      `CHK({engineIdle, memOut.req, txValid}, 3'b100)
      rst_n <= 1;
      txPkt(1, 0, 32'h3000_0000, 0);
      for (i = 0; i < 6; i++) txPkt(1 + i % 3, i % 2, $random(seed) & 32'h3000_0000, i == 4);
      for (i = 0; i < 3; i++) rxPkt(9 + ($random(seed) & 7), i % 2);
      conclude();
   end
endmodule
